// ### bench/reset_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module reset_host_model (
   // supervisor pin drive
   input wire logic i_reset_n,
   input wire logic i_reset_oe,
   // level the host sees
   output logic o_pin
);
   // open drain
   // pull-up wins when released, so a stuck driver shows as a low pin
   assign o_pin = i_reset_oe ? i_reset_n : 1'b1;
endmodule
`default_nettype wire

// ### bench/supervisor_watchdog_reset_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module supervisor_watchdog_reset_monitor (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // watched ports
   input wire logic i_wdog_period_sel_hi,
   input wire logic i_wdog_period_sel_lo,
   input wire logic i_wdog_kick,
   input wire logic i_supply_low,
   input wire logic o_reset_n,
   input wire logic o_reset_oe,
   input wire logic o_wdog_expired
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   // timing relations at the pins
   drop_fast_a: assert property (i_supply_low |=> o_reset_oe) else $error("slow drop");
   pin_low_a: assert property (o_reset_oe |-> !o_reset_n) else $error("pin");
   off_quiet_a: assert property ($rose(o_wdog_expired) |->
      $past({i_wdog_period_sel_hi, i_wdog_period_sel_lo}) != 2'h3) else $error("off fired");
   fire_hold_a: assert property ($rose(o_wdog_expired) |-> o_reset_oe [*7])
      else $error("short hold");
   power_hold_a: assert property ($fell(i_rst) |-> o_reset_oe [*8]) else $error("pwr");
   kick_clr_a: assert property ($fell(o_wdog_expired) |-> $past(i_wdog_kick))
      else $error("clr");
   short_min_a: assert property (i_wdog_kick && !i_wdog_period_sel_lo && i_wdog_period_sel_hi
      |=> (!$rose(o_wdog_expired)) [*8]) else $error("early");
   cover property ($rose(o_wdog_expired));
   cover property ($fell(o_reset_oe));
   cover property (i_supply_low ##1 o_reset_oe);
endmodule
bind supervisor_watchdog_reset supervisor_watchdog_reset_monitor u_mon (.i_clk, .i_rst,
   .i_wdog_period_sel_hi, .i_wdog_period_sel_lo, .i_wdog_kick, .i_supply_low, .o_reset_n,
   .o_reset_oe, .o_wdog_expired);
`default_nettype wire

// ### bench/supervisor_watchdog_reset_tb.sv
`timescale 1ns/1ps
`default_nettype none
module supervisor_watchdog_reset_tb;
   import supervisor_pkg::*;
   logic clk = 1'b0, rst = 1'b1, hi = 1'b0, lo = 1'b0, kick = 1'b0, low = 1'b0;
   logic pin, rn, oe, expd;
   int n_errors = 0, comparisons = 0, n;
   // shortened counts keep the run small
   supervisor_watchdog_reset #(.tick_div(2), .wdog_long(20), .wdog_mid(10), .wdog_short(5),
      .wdog_hold(4)) DUT (.i_clk(clk), .i_rst(rst),
      .i_wdog_period_sel_hi(hi), .i_wdog_period_sel_lo(lo), .i_wdog_kick(kick),
      .i_supply_low(low), .i_reset_pin(pin), .o_reset_n(rn), .o_reset_oe(oe),
      .o_wdog_expired(expd));
   reset_host_model host (.i_reset_n(rn), .i_reset_oe(oe), .o_pin(pin));
   initial forever #5 clk = ~clk;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up();
      $display("comparisons %0d errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // bounded wait, counts edges until flag or oe equals v
   task automatic wait_for(input bit f, input logic v, output int k);
      #1;
      for (k = 0; (f ? expd : oe) !== v; k++) begin
         if (k > 20000) begin
            n_errors++;
            wrap_up();
         end
         @(posedge clk);
         #1;
      end
   endtask
   task automatic t_periods();
      int lim[3] = '{20, 10, 5};
      for (int c = 0; c < 3; c++) begin
         @(posedge clk) {hi, lo} <= c[1:0];
         kick <= 1'b1;
         @(posedge clk) kick <= 1'b0;
         wait_for(1, 1'b1, n);
         check(n >= 2 * lim[c] - 3 && n <= 2 * lim[c] + 2, 1);
         check(pin, 1'b0);
         wait_for(0, 1'b0, n);
         check(n >= 6 && n <= 11, 1);
      end
      $display("periods done");
   endtask
   task automatic t_off_kick();
      @(posedge clk) {hi, lo} <= sel_off;
      kick <= 1'b1;
      @(posedge clk) kick <= 1'b0;
      repeat (60) @(posedge clk);
      #1 check(expd, 1'b0);
      @(posedge clk) {hi, lo} <= sel_short;
      repeat (8) begin
         @(posedge clk) kick <= 1'b1;
         @(posedge clk) kick <= 1'b0;
         repeat (4) @(posedge clk);
      end
      #1 check({expd, oe}, 2'h0);
      $display("off and kick done");
   endtask
   task automatic t_supply();
      @(posedge clk) low <= 1'b1;
      @(posedge clk);
      #1 check(oe, 1'b1);
      repeat (20) @(posedge clk);
      low <= 1'b0;
      wait_for(0, 1'b0, n);
      check(n >= 2 * powerup_ticks - 2 && n <= 2 * powerup_ticks + 4, 1);
      $display("supply done");
   endtask
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      wait_for(0, 1'b0, n);
      check(n >= 2 * powerup_ticks - 2 && n <= 2 * powerup_ticks + 4, 1);
      check(pin, 1'b1);
      t_periods();
      t_off_kick();
      t_supply();
      wrap_up();
   end
endmodule
`default_nettype wire

// ### src/supervisor_pkg.sv
package supervisor_pkg;
   // crystal timebase
   localparam int unsigned xtal_hz = 32768;
   localparam int unsigned clk_hz = 100_000_000;
   // period select codes
   localparam logic [1:0] sel_long = 2'h0;
   localparam logic [1:0] sel_mid = 2'h1;
   localparam logic [1:0] sel_short = 2'h2;
   localparam logic [1:0] sel_off = 2'h3;
   // nominal times in milliseconds
   localparam int unsigned wdog_long_ms = 1750;
   localparam int unsigned wdog_mid_ms = 750;
   localparam int unsigned wdog_short_ms = 250;
   localparam int unsigned wdog_reset_ms = 250;
   localparam int unsigned powerup_ms = 250;
   // crystal ticks for each time
   localparam int unsigned wdog_long_ticks = wdog_long_ms * xtal_hz / 1000;
   localparam int unsigned wdog_mid_ticks = wdog_mid_ms * xtal_hz / 1000;
   localparam int unsigned wdog_short_ticks = wdog_short_ms * xtal_hz / 1000;
   localparam int unsigned wdog_reset_ticks = wdog_reset_ms * xtal_hz / 1000;
   localparam int unsigned powerup_ticks = powerup_ms * xtal_hz / 1000;
   // supply drop latency in ns, longest time rounds down
   localparam int unsigned drop_latency_ns = 500;
   localparam int unsigned drop_latency_cyc = drop_latency_ns / (1_000_000_000 / clk_hz);
   // divider from system clock to crystal tick
   localparam int unsigned tick_div_cyc = clk_hz / xtal_hz;
   localparam int unsigned tick_cnt_w = 16;
endpackage

// ### src/supervisor_watchdog_reset.sv
// How it works
// [RL1] watchdog period from crystal, three selectable lengths
// [RL2] watchdog expiry holds reset low 250 ms
// [RL3] power-up holds reset low 250 ms
// [RL4] low supply pulls reset within 500 ns
// [RL5] code 11 disables the watchdog entirely
// [RL6] reset output active low, open drain
// [RL7] host access restarts watchdog count at zero
`timescale 1ns/1ps
`default_nettype none
module supervisor_watchdog_reset #(
   parameter int unsigned tick_div = supervisor_pkg::tick_div_cyc,
   parameter int unsigned wdog_long = supervisor_pkg::wdog_long_ticks,
   parameter int unsigned wdog_mid = supervisor_pkg::wdog_mid_ticks,
   parameter int unsigned wdog_short = supervisor_pkg::wdog_short_ticks,
   parameter int unsigned wdog_hold = supervisor_pkg::wdog_reset_ticks,
   parameter int unsigned powerup_hold = supervisor_pkg::powerup_ticks
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // watchdog control
   input wire logic i_wdog_period_sel_hi,
   input wire logic i_wdog_period_sel_lo,
   input wire logic i_wdog_kick,
   // supply monitor, high while supply under supply_trip_threshold
   input wire logic i_supply_low,
   // open-drain reset pin
   input wire logic i_reset_pin,
   output logic o_reset_n,
   output logic o_reset_oe,
   // status
   output logic o_wdog_expired
);
   import supervisor_pkg::*;

   localparam int unsigned cw = tick_cnt_w;

   // elaboration checks; every count shares one counter width
   initial begin
      if (wdog_long >= 65536 || wdog_hold >= 65536 || powerup_hold >= 65536) begin
         $error("counts exceed counter width");
      end
      if (wdog_mid >= 65536 || wdog_short >= 65536) begin
         $error("periods exceed counter width");
      end
      if (wdog_short == 0 || wdog_hold == 0 || powerup_hold == 0) begin
         $error("counts must be nonzero");
      end
      // a zero mid or long period would wrap the compare and fire only when the count reaches all ones
      if (wdog_mid == 0 || wdog_long == 0) begin
         $error("periods must be nonzero");
      end
      // codes run long, mid, short; swapped lengths point to a wiring slip
      if (wdog_short > wdog_mid || wdog_mid > wdog_long) begin
         $error("period lengths out of order");
      end
      // the divider needs two cycles at least to make a one-cycle pulse
      if (tick_div < 2) begin
         $error("tick_div too small");
      end
      // the hold compare subtracts one, so the counter needs two bits at least
      if (cw < 2) begin
         $error("counter width too small");
      end
   end

   // one-hot sequencer states
   typedef enum logic [2:0] {
      st_powerup = 3'h1,
      st_run = 3'h2,
      st_hold = 3'h4
   } state_type;

   // sequencer and timebase
   state_type state_q;
   logic tick;

   // counters, both in crystal ticks
   logic [cw-1:0] wdog_cnt_q;
   logic [cw-1:0] hold_cnt_q;

   // period decode
   logic [1:0] sel;
   logic [cw-1:0] limit;
   logic wdog_off;

   // reset request and its registered level
   logic wdog_fire;
   logic reset_want;
   logic reset_q;

   // selected period in ticks; sel_off gives no limit
   function automatic logic [cw-1:0] period_ticks(input logic [1:0] s);
      unique case (s)
         sel_long: period_ticks = cw'(wdog_long);
         sel_mid: period_ticks = cw'(wdog_mid);
         sel_short: period_ticks = cw'(wdog_short);
         default: period_ticks = '0;
      endcase
   endfunction

   // true for the code that switches the watchdog off
   function automatic logic period_off(input logic [1:0] s);
      period_off = (s == sel_off);
   endfunction

   // one shared tick paces every timeout, so all of them drift together
   // with the crystal rate and never against each other

   xtal_tick_div #(
      .div_cyc(tick_div)
   ) u_div (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .o_tick(tick)
   );

   assign sel = {i_wdog_period_sel_hi, i_wdog_period_sel_lo};
   assign limit = period_ticks(sel);
   assign wdog_off = period_off(sel);
   // [RL1] select period limit
   // [RL5] disabled code never fires
   // the compare uses >= so a period shortened under a running count fires on the next tick
   assign wdog_fire = (state_q == st_run) && !wdog_off && tick &&
                      (wdog_cnt_q >= limit - cw'(1));

   // watchdog count; a kick wins over ticking
   // the count sits at zero outside run, so leaving a hold starts a full period
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         wdog_cnt_q <= '0;
      // [RL7] kick clears count
      end else if (i_wdog_kick || state_q != st_run || wdog_off) begin
         wdog_cnt_q <= '0;
      end else if (tick) begin
         wdog_cnt_q <= wdog_cnt_q + cw'(1);
      end
   end

   // reset sequencing; a supply drop restarts the power-up hold
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         state_q <= st_powerup;
         hold_cnt_q <= '0;
      end else if (i_supply_low) begin
         state_q <= st_powerup;
         hold_cnt_q <= '0;
      end else begin
         unique case (state_q)
            // [RL3] power-up hold
            st_powerup: begin
               if (tick) begin
                  if (hold_cnt_q >= cw'(powerup_hold - 1)) begin
                     state_q <= st_run;
                     hold_cnt_q <= '0;
                  end else begin
                     hold_cnt_q <= hold_cnt_q + cw'(1);
                  end
               end
            end
            // wait here; kicks only touch the watchdog count and the expiry flag
            st_run: begin
               if (wdog_fire) begin
                  state_q <= st_hold;
                  hold_cnt_q <= '0;
               end
            end
            // [RL2] watchdog reset hold
            st_hold: begin
               if (tick) begin
                  if (hold_cnt_q >= cw'(wdog_hold - 1)) begin
                     state_q <= st_run;
                     hold_cnt_q <= '0;
                  end else begin
                     hold_cnt_q <= hold_cnt_q + cw'(1);
                  end
               end
            end
            // an illegal code falls back to the power-up hold
            default: begin
               state_q <= st_powerup;
               hold_cnt_q <= '0;
            end
         endcase
      end
   end

   // reset request; the supply term bypasses the sequencer so it never waits
   // for the state machine to leave run
   assign reset_want = i_supply_low || wdog_fire || (state_q != st_run);

   // registered reset level; one cycle after supply drop, well under the latency
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         reset_q <= 1'b1;
      // [RL4] fast supply reset
      end else begin
         reset_q <= reset_want;
      end
   end

   // sticky expiry flag, cleared by a kick; expiry wins over the kick
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_wdog_expired <= 1'b0;
      end else if (wdog_fire) begin
         o_wdog_expired <= 1'b1;
      end else if (i_wdog_kick) begin
         o_wdog_expired <= 1'b0;
      end
   end

   // [RL6] open-drain active low pin
   // data stays low and only the enable moves, so the pin is never driven high
   assign o_reset_n = 1'b0;
   assign o_reset_oe = reset_q;
endmodule
`default_nettype wire

// ### src/xtal_tick_div.sv
`timescale 1ns/1ps
`default_nettype none
// one-cycle enable at the crystal rate, so all timeouts count crystal ticks
module xtal_tick_div #(
   parameter int unsigned div_cyc = 3051
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // tick enable
   output logic o_tick
);
   initial begin
      if (div_cyc < 2 || div_cyc > 65535) begin
         $error("div_cyc out of range");
      end
   end
   logic [15:0] cnt_q;
   // free-running divider
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         cnt_q <= 16'h0;
         o_tick <= 1'b0;
      end else if (cnt_q == 16'(div_cyc - 1)) begin
         cnt_q <= 16'h0;
         o_tick <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 16'h1;
         o_tick <= 1'b0;
      end
   end
endmodule
`default_nettype wire
